/* File: hdl/pd_pwm_dac_outputs.sv */
// pulse-width dac outputs: eight coarse channels and one fine channel,
// programmed through special function registers, with port pin takeover.
// assumes a single-cycle register port synchronous to mclk_i.
module pd_pwm_dac_outputs (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] p2_latch_i,
   input  wire logic       p34_latch_i,
   output logic      [7:0] sfr_rdata_o,
   output logic      [7:0] p2_pin_o,
   output logic            p34_pin_o
);

   logic [7:0]  coarse_q [pd_pkg::NUM_COARSE];
   logic [7:0]  fine_low_q;
   logic [7:0]  fine_high_q;
   logic        fine_load_q;
   logic [7:0]  coarse_out_q;
   logic        fine_out;
   logic [3:0]  wr_idx;
   logic [3:0]  rd_idx;
   logic [13:0] fine_value;

   pd_tick_if tick ();

   ////////////////////////////////////////////////////////////////////////////
   // register decode, shared by the write and read paths

   function automatic logic [3:0] sfr_index(input logic [7:0] a);
      logic [3:0] idx;
      idx = pd_pkg::IDX_NONE;
      for (int i = 0; i < pd_pkg::NUM_COARSE; i++) begin
         if (a == pd_pkg::ADDR_COARSE[i]) begin
            idx = 4'(i);
         end
      end
      if (a == pd_pkg::ADDR_FINE_LOW) begin
         idx = pd_pkg::IDX_FINE_LOW;
      end
      if (a == pd_pkg::ADDR_FINE_HIGH) begin
         idx = pd_pkg::IDX_FINE_HIGH;
      end
      return idx;
   endfunction

   assign wr_idx = sfr_index(sfr_addr_i);
   assign rd_idx = sfr_index(sfr_addr_i);

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   // one register per coarse channel
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < pd_pkg::NUM_COARSE; i++) begin
            coarse_q[i] <= pd_pkg::COARSE_RESET;
         end
      end else if (sfr_wr_i && !wr_idx[3]) begin
         coarse_q[wr_idx[2:0]] <= sfr_wdata_i;
      end
   end

   // low byte alone only stages data; nothing reaches the generator
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fine_low_q <= pd_pkg::FINE_RESET;
      end else if (sfr_wr_i && wr_idx == pd_pkg::IDX_FINE_LOW) begin
         fine_low_q <= sfr_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fine_high_q <= pd_pkg::FINE_RESET;
      end else if (sfr_wr_i && wr_idx == pd_pkg::IDX_FINE_HIGH) begin
         fine_high_q <= sfr_wdata_i;
      end
   end

   // load strobe follows the high byte write by one clock, once it is stored
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fine_load_q <= 1'b0;
      end else begin
         fine_load_q <= sfr_wr_i && (wr_idx == pd_pkg::IDX_FINE_HIGH);
      end
   end

   // value bit 13 is the msb; low byte bit 7 is value bit 7
   assign fine_value = {fine_high_q[pd_pkg::WIDTH_MSB:0], fine_low_q};

   ////////////////////////////////////////////////////////////////////////////
   // register reads

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sfr_rdata_o <= pd_pkg::UNMAPPED_READ;
      end else if (sfr_rd_i) begin
         if (!rd_idx[3]) begin
            sfr_rdata_o <= coarse_q[rd_idx[2:0]];
         end else if (rd_idx == pd_pkg::IDX_FINE_LOW) begin
            sfr_rdata_o <= fine_low_q;
         end else if (rd_idx == pd_pkg::IDX_FINE_HIGH) begin
            sfr_rdata_o <= fine_high_q;
         end else begin
            sfr_rdata_o <= pd_pkg::UNMAPPED_READ;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse generation

   pd_step_timer u_timer (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .tick    (tick.timer)
   );

   pd_fine_unit u_fine (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (fine_load_q),
      .value_i (fine_value),
      .tick    (tick.user),
      .out_o   (fine_out)
   );

   // coarse period is the low six bits of the shared step count
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         coarse_out_q <= 8'h00;
      end else begin
         for (int i = 0; i < pd_pkg::NUM_COARSE; i++) begin
            coarse_out_q[i] <= tick.step_cnt[pd_pkg::COARSE_BITS-1:0]
                               < coarse_q[i][pd_pkg::WIDTH_MSB:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin takeover; with the takeover bit set the pin ignores its latch bit

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p2_pin_o <= 8'hFF;
      end else begin
         p2_pin_o[0] <= fine_high_q[pd_pkg::TAKEOVER_BIT] ? fine_out : p2_latch_i[0];
         for (int i = 1; i < 8; i++) begin
            p2_pin_o[i] <= coarse_q[i-1][pd_pkg::TAKEOVER_BIT] ? coarse_out_q[i-1]
                                                              : p2_latch_i[i];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p34_pin_o <= 1'b1;
      end else begin
         p34_pin_o <= coarse_q[7][pd_pkg::TAKEOVER_BIT] ? coarse_out_q[7] : p34_latch_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_high_write;
      sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_FINE_HIGH;
   endsequence

   sequence s_load_then_value;
      ##1 fine_load_q && fine_value == {$past(sfr_wdata_i[5:0]), $past(fine_low_q)};
   endsequence

   AST_FINE_COMPOSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_high_write |-> s_load_then_value)
      else $error("fine value not built from high and low bytes");

   AST_LOW_NO_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_FINE_LOW) |=> !fine_load_q)
      else $error("low byte write started a load");

   AST_COARSE_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_COARSE[3]) |=> coarse_q[3] == $past(sfr_wdata_i))
      else $error("coarse channel three register not written");

   AST_COARSE_HIGH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (tick.step_cnt[5:0] < coarse_q[2][5:0]) |=> coarse_out_q[2])
      else $error("coarse output low inside its width");

   AST_COARSE_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (tick.step_cnt[5:0] >= coarse_q[2][5:0]) |=> !coarse_out_q[2])
      else $error("coarse output high past its width");

   AST_TAKEOVER_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !coarse_q[0][7] |=> p2_pin_o[1] == $past(p2_latch_i[1]))
      else $error("pin not following latch with takeover clear");

   AST_TAKEOVER_ON: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      coarse_q[0][7] |=> p2_pin_o[1] == $past(coarse_out_q[0]))
      else $error("pin not driven by channel zero");

   AST_P34_TAKEOVER: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      coarse_q[7][7] |=> p34_pin_o == $past(coarse_out_q[7]))
      else $error("port three line four not driven by channel seven");

   AST_FINE_PIN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      fine_high_q[7] |=> p2_pin_o[0] == $past(fine_out))
      else $error("port two line zero not driven by fine channel");

   AST_FINE_PIN_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !fine_high_q[7] |=> p2_pin_o[0] == $past(p2_latch_i[0]))
      else $error("port two line zero not following latch");

   AST_RD_FINE_LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_rd_i && sfr_addr_i == pd_pkg::ADDR_FINE_LOW) |=> sfr_rdata_o == $past(fine_low_q))
      else $error("fine low byte read back wrong");

   AST_RD_FINE_HIGH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_rd_i && sfr_addr_i == pd_pkg::ADDR_FINE_HIGH) |=> sfr_rdata_o == $past(fine_high_q))
      else $error("fine high byte read back wrong");

   AST_RD_COARSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_rd_i && sfr_addr_i == pd_pkg::ADDR_COARSE[5]) |=> sfr_rdata_o == $past(coarse_q[5]))
      else $error("coarse channel five read back wrong");

   AST_RD_UNMAPPED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_rd_i && rd_idx == pd_pkg::IDX_NONE) |=> sfr_rdata_o == pd_pkg::UNMAPPED_READ)
      else $error("unmapped read not zero");

   AST_RD_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !sfr_rd_i |=> $stable(sfr_rdata_o))
      else $error("read data changed without a read");

   AST_HIGH_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_FINE_HIGH) |=> fine_high_q == $past(sfr_wdata_i))
      else $error("fine high byte not written");

   AST_LOW_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_FINE_LOW) |=> fine_low_q == $past(sfr_wdata_i))
      else $error("fine low byte not written");

   AST_LOW_KEEPS_HIGH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_FINE_LOW) |=> $stable(fine_high_q))
      else $error("low byte write disturbed the high byte");

   AST_UNMAPPED_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && wr_idx == pd_pkg::IDX_NONE) |=> $stable(fine_low_q) && $stable(fine_high_q))
      else $error("unmapped write changed a fine register");

   AST_COARSE_SEPARATE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sfr_wr_i && sfr_addr_i == pd_pkg::ADDR_COARSE[3]) |=> $stable(coarse_q[2]))
      else $error("coarse write reached a neighbouring channel");

   AST_P34_TAKEOVER_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !coarse_q[7][7] |=> p34_pin_o == $past(p34_latch_i))
      else $error("port three line four not following latch");

   AST_CH6_TAKEOVER: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      coarse_q[6][7] |=> p2_pin_o[7] == $past(coarse_out_q[6]))
      else $error("port two line seven not driven by channel six");

   AST_CH6_TAKEOVER_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !coarse_q[6][7] |=> p2_pin_o[7] == $past(p2_latch_i[7]))
      else $error("port two line seven not following latch");

   AST_COARSE_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (coarse_q[0][5:0] == 6'h00) |=> !coarse_out_q[0])
      else $error("zero width coarse output went high");

   AST_COARSE_FULL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (coarse_q[1][5:0] == 6'h3F && tick.step_cnt[5:0] != 6'h3F) |=> coarse_out_q[1])
      else $error("full width coarse output low early");

   // wrap of the 64-step period; a write in the same clock could move the width
   sequence s_ch4_wrap;
      tick.step_en && tick.step_cnt[5:0] == 6'h3F && coarse_q[4][5:0] != 6'h00 && !sfr_wr_i;
   endsequence

   AST_COARSE_RESTART: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_ch4_wrap |-> ##2 coarse_out_q[4])
      else $error("coarse output did not rise at period start");

endmodule

/* File: hdl/pd_pkg.sv */
// constants for the pulse-width dac outputs: register addresses, field
// positions, reset values and step timing.
// assumes an 8-bit special function register port and one device clock.
package pd_pkg;

   // register addresses on the special function register port
   localparam logic [7:0] ADDR_FINE_LOW  = 8'hD2;
   localparam logic [7:0] ADDR_FINE_HIGH = 8'hD3;
   localparam logic [7:0] ADDR_COARSE [8] = '{8'hD5, 8'hD6, 8'hD7, 8'hDC,
                                             8'hDD, 8'hDE, 8'hDF, 8'hD4};

   // register index space seen by the decoder
   localparam logic [3:0] IDX_FINE_LOW  = 4'h8;
   localparam logic [3:0] IDX_FINE_HIGH = 4'h9;
   localparam logic [3:0] IDX_NONE      = 4'hF;

   // reset values
   localparam logic [7:0] COARSE_RESET = 8'h40;
   localparam logic [7:0] FINE_RESET   = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // field positions
   localparam int TAKEOVER_BIT   = 7;
   localparam int WIDTH_MSB      = 5;
   localparam int FINE_B7_BIT    = 7;
   localparam int EXT_MSB        = 6;
   localparam int NUM_COARSE     = 8;
   localparam int COARSE_BITS    = 6;
   localparam int FINE_STEP_BITS = 7;
   localparam int FINE_BITS      = 14;

   // timing: one width step, in nanoseconds, at the crystal rate
   localparam int XTAL_MHZ     = 12;
   localparam int STEP_NS      = 333;
   localparam int STEP_CYCLES  = (STEP_NS * XTAL_MHZ + 999) / 1000;
   localparam int COARSE_STEPS = 64;
   localparam int FINE_STEPS   = 128;
   localparam logic [1:0] PRESCALE_LAST = 2'(STEP_CYCLES - 1);
   localparam logic [6:0] FINE_LAST    = 7'(FINE_STEPS - 1);

endpackage

/* File: hdl/pd_tick_if.sv */
// step timing shared between the timer and the pulse generators.
// assumes both ends run on the same device clock.
interface pd_tick_if;
   logic       step_en;
   logic [6:0] step_cnt;

   modport timer (output step_en, output step_cnt);
   modport user  (input  step_en, input  step_cnt);
endinterface

/* File: hdl/pd_step_timer.sv */
// step prescaler and shared step counter for all pulse channels.
// assumes one clock; the coarse count is the low six bits of the step count.
module pd_step_timer (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   pd_tick_if.timer  tick
);

   logic [1:0] prescale_q;
   logic [1:0] prescale_d;

   assign prescale_d = (prescale_q == pd_pkg::PRESCALE_LAST) ? 2'h0 : 2'(prescale_q + 2'h1);

   ////////////////////////////////////////////////////////////////////////////
   // one width step every four device clocks
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prescale_q   <= 2'h0;
         tick.step_en <= 1'b0;
      end else begin
         prescale_q   <= prescale_d;
         tick.step_en <= (prescale_q == pd_pkg::PRESCALE_LAST);
      end
   end

   // free-running step count; 64 divides 128 so both periods share it
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick.step_cnt <= 7'h00;
      end else if (tick.step_en) begin
         tick.step_cnt <= 7'(tick.step_cnt + 7'h01);
      end
   end

   sequence s_step_gap;
      !tick.step_en [*3] ##1 tick.step_en;
   endsequence

   AST_STEP_SPACING: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      tick.step_en |=> s_step_gap)
      else $error("step enable not every four clocks");

   AST_FINE_WRAP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (tick.step_en && tick.step_cnt == pd_pkg::FINE_LAST) |=> tick.step_cnt == 7'h00)
      else $error("fine period is not 128 steps");

endmodule

/* File: hdl/pd_fine_unit.sv */
// fourteen-bit fine pulse generator with spread pulse extension.
// assumes load_i pulses once when the high byte has been written.
module pd_fine_unit (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        load_i,
   input  wire logic [13:0] value_i,
   pd_tick_if.user          tick,
   output logic             out_o
);

   logic [13:0] active_q;
   logic [13:0] pend_q;
   logic        pend_v_q;
   logic [6:0]  frame_q;
   logic        period_end;
   logic        ext;
   logic [7:0]  width;

   function automatic logic [6:0] rev7(input logic [6:0] v);
      logic [6:0] r;
      r = 7'h00;
      for (int i = 0; i < 7; i++) begin
         r[i] = v[6 - i];
      end
      return r;
   endfunction

   assign period_end = tick.step_en && (tick.step_cnt == pd_pkg::FINE_LAST);
   // bit-reversed frame count spreads the lengthened periods evenly
   assign ext   = rev7(frame_q) < active_q[pd_pkg::EXT_MSB:0];
   assign width = {1'b0, active_q[13:7]} + {7'h00, ext};

   ////////////////////////////////////////////////////////////////////////////
   // new value waits for the period boundary to avoid a runt pulse
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q   <= 14'h0000;
         pend_v_q <= 1'b0;
      end else if (load_i) begin
         pend_q   <= value_i;
         pend_v_q <= 1'b1;
      end else if (period_end) begin
         pend_v_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active_q <= 14'h0000;
      end else if (period_end && pend_v_q) begin
         active_q <= pend_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_q <= 7'h00;
      end else if (period_end) begin
         frame_q <= 7'(frame_q + 7'h01);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_o <= 1'b0;
      end else begin
         out_o <= {1'b0, tick.step_cnt} < width;
      end
   end

   AST_FINE_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !(period_end && pend_v_q) |=> $stable(active_q))
      else $error("fine value changed without a high byte write");

   AST_FINE_BASE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (tick.step_cnt < active_q[13:7]) |=> out_o)
      else $error("fine output low inside base width");

   AST_FINE_EXT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (tick.step_cnt == active_q[13:7] && !(&active_q[13:7])) |=> out_o == $past(ext))
      else $error("fine extension step wrong");

   AST_FRAME_STEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      period_end |=> frame_q == 7'($past(frame_q) + 7'h01))
      else $error("extension frame did not advance");

endmodule

/* File: test/pd_analog_load.sv */
// far-side model: filtered-pulse loads on the nine takeover pins.
// assumes pins are registered on mclk_i; reports high time and period in clocks.
module pd_analog_load (
   input  wire logic       mclk_i,
   input  wire logic [8:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] hi_len  [9] = '{default: 16'h0000};
   logic [15:0] per_len [9] = '{default: 16'h0000};
   logic [15:0] hi_cnt  [9] = '{default: 16'h0000};
   logic [15:0] per_cnt [9] = '{default: 16'h0000};
   int          rises   [9] = '{default: 0};
   logic [8:0]  prev_q       = 9'h000;

   ////////////////////////////////////////////////////////////////////////////
   // an rc filter only sees duty and period, so the load keeps those plus a count of rises
   always @(posedge mclk_i) begin
      for (int i = 0; i < 9; i++) begin
         if (pin_i[i] && !prev_q[i]) begin
            per_len[i] <= per_cnt[i];
            per_cnt[i] <= 16'h0001;
            hi_cnt[i]  <= 16'h0001;
            rises[i]   <= rises[i] + 1;
         end else begin
            per_cnt[i] <= per_cnt[i] + 16'h0001;
            if (pin_i[i]) hi_cnt[i] <= hi_cnt[i] + 16'h0001;
            if (!pin_i[i] && prev_q[i]) hi_len[i] <= hi_cnt[i];
         end
      end
      prev_q <= pin_i;
   end
endmodule

/* File: test/pd_pwm_dac_outputs_tb.sv */
// self-checking bench for the pulse-width dac outputs.
// assumes a 10 MHz clock; one step is four clocks whatever the rate.
module pd_pwm_dac_outputs_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic       mclk_i      = 1'b0;
   logic       rst_n_i     = 1'b0;
   logic [7:0] sfr_addr_i  = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic       sfr_wr_i    = 1'b0;
   logic       sfr_rd_i    = 1'b0;
   logic [7:0] p2_latch_i  = 8'hFF;
   logic       p34_latch_i = 1'b1;
   logic [7:0] sfr_rdata_o;
   logic [7:0] p2_pin_o;
   logic       p34_pin_o;
   int         fail_count  = 0;
   int         comparisons = 0;
   int         cycles      = 0;
   int         ext_cnt;
   int         first_ext;
   int         last_ext;
   int         r_fine;
   int         r_ch1;
   logic [5:0] cw [8] = '{6'h01, 6'h3F, 6'h20, 6'h05, 6'h11, 6'h28, 6'h02, 6'h3E};

   always #50 mclk_i = ~mclk_i;

   pd_pwm_dac_outputs uut (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .sfr_addr_i  (sfr_addr_i),
      .sfr_wdata_i (sfr_wdata_i),
      .sfr_wr_i    (sfr_wr_i),
      .sfr_rd_i    (sfr_rd_i),
      .p2_latch_i  (p2_latch_i),
      .p34_latch_i (p34_latch_i),
      .sfr_rdata_o (sfr_rdata_o),
      .p2_pin_o    (p2_pin_o),
      .p34_pin_o   (p34_pin_o)
   );

   pd_analog_load load (
      .mclk_i (mclk_i),
      .pin_i  ({p34_pin_o, p2_pin_o})
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 100000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge mclk_i);
      sfr_wr_i    <= 1'b0;
   endtask

   // data stands until the next read, so sample a whole clock after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge mclk_i);
      sfr_rd_i   <= 1'b0;
      @(posedge mclk_i);
      check({8'h00, sfr_rdata_o}, {8'h00, exp});
   endtask

   task automatic wait_rise(input int idx);
      int r0;
      r0 = load.rises[idx];
      for (int k = 0; k < 600; k++) begin
         if (load.rises[idx] != r0) break;
         @(posedge mclk_i);
      end
      check(16'(load.rises[idx] - r0), 16'h0001);
   endtask

   // third edge: the last full period is clean even if a write landed mid-period
   task automatic pulse_chk(input int idx, input logic [15:0] hi, input logic [15:0] per);
      repeat (3) wait_rise(idx);
      check(load.hi_len[idx], hi);
      check(load.per_len[idx], per);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 8; i++) rd_chk(pd_pkg::ADDR_COARSE[i], pd_pkg::COARSE_RESET);
      rd_chk(pd_pkg::ADDR_FINE_LOW, 8'h00);
      rd_chk(pd_pkg::ADDR_FINE_HIGH, 8'h00);
      rd_chk(8'h00, 8'h00);
      @(posedge mclk_i);
      p2_latch_i  <= 8'hA5;
      p34_latch_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      check({7'h00, p34_pin_o, p2_pin_o}, 16'h00A5);
      p2_latch_i  <= 8'hFF;
      p34_latch_i <= 1'b1;
      for (int i = 0; i < 8; i++) wr(pd_pkg::ADDR_COARSE[i], {1'b1, 1'(i), cw[i]});
      for (int i = 0; i < 8; i++) rd_chk(pd_pkg::ADDR_COARSE[i], {1'b1, 1'(i), cw[i]});
      for (int i = 0; i < 8; i++) pulse_chk(i + 1, {8'h00, cw[i], 2'b00}, 16'h0100);
      // width zero stays low; takeover off hands a running channel back to its latch
      wr(pd_pkg::ADDR_COARSE[0], 8'h80);
      wr(pd_pkg::ADDR_COARSE[1], 8'h20);
      @(posedge mclk_i);
      p2_latch_i <= 8'hFB;
      repeat (10) @(posedge mclk_i);
      r_fine = load.rises[1];
      r_ch1  = load.rises[2];
      repeat (300) @(posedge mclk_i);
      check(16'(load.rises[1] - r_fine), 16'h0000);
      check(16'(load.rises[2] - r_ch1), 16'h0000);
      check({14'h0000, p2_pin_o[2:1]}, 16'h0000);
      p2_latch_i <= 8'hFF;
      wr(pd_pkg::ADDR_FINE_LOW, 8'h80);
      wr(pd_pkg::ADDR_FINE_HIGH, 8'h95);
      rd_chk(pd_pkg::ADDR_FINE_LOW, 8'h80);
      rd_chk(pd_pkg::ADDR_FINE_HIGH, 8'h95);
      pulse_chk(0, 16'h00AC, 16'h0200);
      wr(pd_pkg::ADDR_FINE_LOW, 8'h02);
      pulse_chk(0, 16'h00AC, 16'h0200);
      wr(pd_pkg::ADDR_FINE_HIGH, 8'h95);
      repeat (2) wait_rise(0);
      ext_cnt   = 0;
      first_ext = 0;
      last_ext  = 0;
      for (int k = 0; k < 128; k++) begin
         wait_rise(0);
         if (load.hi_len[0] == 16'h00AC) begin
            if (ext_cnt == 0) first_ext = k;
            last_ext = k;
            ext_cnt++;
         end else begin
            check(load.hi_len[0], 16'h00A8);
         end
      end
      check(16'(ext_cnt), 16'h0002);
      check(16'(last_ext - first_ext), 16'h0040);
      wr(pd_pkg::ADDR_FINE_HIGH, 8'h15);
      @(posedge mclk_i);
      p2_latch_i <= 8'hFE;
      repeat (4) @(posedge mclk_i);
      check({15'h0000, p2_pin_o[0]}, 16'h0000);
      wr(8'hD8, 8'hFF);
      rd_chk(8'hD8, 8'h00);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check({7'h00, p34_pin_o, p2_pin_o}, 16'h01FF);
      rst_n_i <= 1'b1;
      rd_chk(pd_pkg::ADDR_COARSE[0], pd_pkg::COARSE_RESET);
      finish_test();
   end
endmodule
